// [logic/dmr_conv_if.sv]
// conversion result carrier between the bank and its result slots
`timescale 1ns/1ns
`default_nettype none
interface dmr_conv_if;
  logic valid;
  logic [3:0] chan;
  logic [11:0] data;
  modport src (output valid, output chan, output data);
  modport dst (input valid, input chan, input data);
endinterface
`default_nettype wire

// [logic/dmr_pkg.sv]
// constants for the diagnostic monitor result register bank
package dmr_pkg;

  // bus widths and channel count
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned NUM_CHAN = 7;

  // register offsets
  localparam logic [7:0] BATTERY_RESULT_HIGH = 8'h56;
  localparam logic [7:0] BATTERY_RESULT_LOW = 8'h57;
  localparam logic [7:0] MIC_BIAS_RESULT_HIGH = 8'h58;
  localparam logic [7:0] MIC_BIAS_RESULT_LOW = 8'h59;
  localparam logic [7:0] INPUT1_POS_RESULT_HIGH = 8'h5A;
  localparam logic [7:0] INPUT1_POS_RESULT_LOW = 8'h5B;
  localparam logic [7:0] INPUT1_NEG_RESULT_HIGH = 8'h5C;
  localparam logic [7:0] INPUT1_NEG_RESULT_LOW = 8'h5D;
  localparam logic [7:0] INPUT2_POS_RESULT_HIGH = 8'h5E;
  localparam logic [7:0] INPUT2_POS_RESULT_LOW = 8'h5F;
  localparam logic [7:0] INPUT2_NEG_RESULT_HIGH = 8'h60;
  localparam logic [7:0] INPUT2_NEG_RESULT_LOW = 8'h61;
  localparam logic [7:0] OUTPUT1_POS_RESULT_HIGH = 8'h62;
  localparam logic [7:0] MAP_FIRST = BATTERY_RESULT_HIGH;
  localparam logic [7:0] MAP_LAST = OUTPUT1_POS_RESULT_HIGH;

  // field positions inside a low register
  localparam int unsigned LOW_NIB_LSB = 4;
  localparam int unsigned CHAN_ID_LSB = 0;

  // channel identifiers, the fixed value of bits 3-0 of each low register
  localparam logic [3:0] CHAN_BATTERY = 4'h0;
  localparam logic [3:0] CHAN_MIC_BIAS = 4'h1;
  localparam logic [3:0] CHAN_INPUT1_POS = 4'h2;
  localparam logic [3:0] CHAN_INPUT1_NEG = 4'h3;
  localparam logic [3:0] CHAN_INPUT2_POS = 4'h4;
  localparam logic [3:0] CHAN_INPUT2_NEG = 4'h5;
  localparam logic [3:0] CHAN_OUTPUT1_POS = 4'h6;

  // values after reset, and the data returned by unmapped reads
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

endpackage

// [logic/dmr_result_regs.sv]
// read-only diagnostic monitor result register bank, top level
// How it works
// [RULE_01] high register returns result upper byte, resets zero
// [RULE_02] low register bits 7-4 hold result nibble
// [RULE_03] battery low register id reads 0
// [RULE_04] mic bias low register id reads 1
// [RULE_05] input1 positive low register id reads 2
// [RULE_06] input1 negative low register id reads 3
// [RULE_07] input2 positive low register id reads 4
// [RULE_08] input2 negative low register id reads 5
// [RULE_09] output1 positive high byte at 0x62
// [RULE_10] battery high byte at 0x56, resets zero
// [RULE_11] pair updates together from one conversion
`timescale 1ns/1ns
`default_nettype none
module dmr_result_regs #(
  parameter int unsigned NUM_CHAN = dmr_pkg::NUM_CHAN
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic conv_valid_i,
  input wire logic [3:0] conv_chan_i,
  input wire logic [11:0] conv_data_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic addr_err_o,
  output logic wr_refused_o,
  output logic [NUM_CHAN-1:0] fresh_o
);

  ////////////////////////////////////////////////////////////////////////
  // channel id table, one entry per slot
  // the id fills bits 3-0 of each low register and never changes

  localparam logic [3:0] CHAN_IDS [7] = '{
    dmr_pkg::CHAN_BATTERY, // [RULE_03]
    dmr_pkg::CHAN_MIC_BIAS, // [RULE_04]
    dmr_pkg::CHAN_INPUT1_POS, // [RULE_05]
    dmr_pkg::CHAN_INPUT1_NEG, // [RULE_06]
    dmr_pkg::CHAN_INPUT2_POS, // [RULE_07]
    dmr_pkg::CHAN_INPUT2_NEG, // [RULE_08]
    dmr_pkg::CHAN_OUTPUT1_POS
  };

  // one carrier feeds every slot; each slot matches its own id
  dmr_conv_if conv ();

  // per slot read-back values and update strobes
  logic [7:0] high_w [NUM_CHAN];
  logic [7:0] low_w [NUM_CHAN];
  logic [NUM_CHAN-1:0] upd_w;

  ////////////////////////////////////////////////////////////////////////
  // conversion strobe onto the carrier

  assign conv.valid = conv_valid_i;
  assign conv.chan = conv_chan_i;
  assign conv.data = conv_data_i;

  ////////////////////////////////////////////////////////////////////////
  // one result slot per monitored channel

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_slot
    dmr_result_slot #(
      .CHAN_ID(CHAN_IDS[g])
    ) u_slot (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .conv(conv),
      .high_o(high_w[g]),
      .low_o(low_w[g]),
      .upd_o(upd_w[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode: even offsets from the base are high bytes, odd are
  // low registers; the map ends on the output1 positive high byte
  // the output1 positive low register lies beyond this map

  logic mapped;
  logic [7:0] rel;
  logic [2:0] sel_chan;
  logic sel_low;

  // rel and the selects mean nothing while mapped is low
  // a channel count above eight would need a wider select
  always_comb begin
    mapped = (addr_i >= dmr_pkg::MAP_FIRST) &&
             (addr_i <= dmr_pkg::MAP_LAST); // [RULE_09] [RULE_10]
    rel = addr_i - dmr_pkg::MAP_FIRST;
    sel_chan = rel[3:1];
    sel_low = rel[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // coherent pair read: a high byte read captures the matching low
  // register, so a following low read returns the same conversion even
  // if a new result lands between the two reads

  logic shadow_vld_q;
  logic shadow_vld_d;
  logic [2:0] shadow_chan_q;
  logic [2:0] shadow_chan_d;
  logic [7:0] shadow_q;
  logic [7:0] shadow_d;
  logic rd_hit;

  // a high read loads the snapshot, any low read retires it
  always_comb begin
    rd_hit = rd_en_i && mapped;
    shadow_vld_d = shadow_vld_q;
    shadow_chan_d = shadow_chan_q;
    shadow_d = shadow_q;
    if (rd_hit && !sel_low) begin
      shadow_vld_d = 1'b1; // [RULE_11]
      shadow_chan_d = sel_chan;
      shadow_d = low_w[sel_chan];
    end else if (rd_hit && sel_low) begin
      shadow_vld_d = 1'b0;
    end
  end

  // shadow registers
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      shadow_vld_q <= 1'b0;
      shadow_chan_q <= 3'h0;
      shadow_q <= 8'h00;
    end else begin
      shadow_vld_q <= shadow_vld_d;
      shadow_chan_q <= shadow_chan_d;
      shadow_q <= shadow_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data mux; unmapped reads return zero and flag an error

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic addr_err_q;
  logic addr_err_d;
  logic wr_ref_q;
  logic wr_ref_d;

  // next read port values; a write raises the refusal flag, and the error flag when unmapped
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = rd_en_i;
    addr_err_d = (rd_en_i || wr_en_i) && !mapped;
    wr_ref_d = wr_en_i; // every field here is read-only
    if (rd_en_i) begin
      if (!mapped) begin
        rdata_d = dmr_pkg::UNMAPPED_DATA;
      end else if (!sel_low) begin
        rdata_d = high_w[sel_chan]; // [RULE_01] [RULE_09] [RULE_10]
      end else if (shadow_vld_q && shadow_chan_q == sel_chan) begin
        rdata_d = shadow_q; // [RULE_11]
      end else begin
        rdata_d = low_w[sel_chan]; // [RULE_02]
      end
    end
  end

  // read port registers
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      addr_err_q <= 1'b0;
      wr_ref_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      addr_err_q <= addr_err_d;
      wr_ref_q <= wr_ref_d;
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign addr_err_o = addr_err_q;
  assign wr_refused_o = wr_ref_q;

  ////////////////////////////////////////////////////////////////////////
  // fresh flags: set by a new result, cleared when the register that
  // closes the pair is read; a new result in the clearing cycle wins

  logic [NUM_CHAN-1:0] fresh_q;
  logic [NUM_CHAN-1:0] fresh_d;
  logic [NUM_CHAN-1:0] fresh_clr;

  // the last channel has no low register here, so its high read
  // closes the pair
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      fresh_clr[i] = rd_hit && (sel_chan == 3'(i)) &&
                     (sel_low || (32'(i) == NUM_CHAN - 1));
      fresh_d[i] = upd_w[i] || (fresh_q[i] && !fresh_clr[i]);
    end
  end

  // fresh flag registers
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      fresh_q <= '0;
    end else begin
      fresh_q <= fresh_d;
    end
  end

  assign fresh_o = fresh_q;

endmodule
`default_nettype wire

// [logic/dmr_result_slot.sv]
// one channel's result pair: high byte and low nibble plus channel id
`timescale 1ns/1ns
`default_nettype none
module dmr_result_slot #(
  parameter logic [3:0] CHAN_ID = 4'h0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  dmr_conv_if.dst conv,
  output logic [7:0] high_o,
  output logic [7:0] low_o,
  output logic upd_o
);

  logic [7:0] high_q;
  logic [7:0] high_d;
  logic [3:0] nib_q;
  logic [3:0] nib_d;
  logic hit;

  // both halves load from the same conversion strobe
  always_comb begin
    hit = conv.valid && (conv.chan == CHAN_ID);
    high_d = high_q;
    nib_d = nib_q;
    if (hit) begin
      high_d = conv.data[11:4]; // [RULE_01] [RULE_11]
      nib_d = conv.data[3:0]; // [RULE_02] [RULE_11]
    end
  end

  // register the pair
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      high_q <= dmr_pkg::HIGH_RESET;
      nib_q <= dmr_pkg::NIB_RESET;
    end else begin
      high_q <= high_d;
      nib_q <= nib_d;
    end
  end

  assign high_o = high_q;
  assign low_o = {nib_q, CHAN_ID}; // fixed id in bits 3-0
  assign upd_o = hit;

endmodule
`default_nettype wire

// [test/dmr_host_mdl.sv]
// host side model: register reads and write attempts
`timescale 1ns/1ns
`default_nettype none
module dmr_host_mdl (
  input wire logic mclk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  input wire logic err_i,
  input wire logic refused_i,
  output logic rd_en_o,
  output logic wr_en_o,
  output logic [7:0] addr_o
);
  initial begin
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    addr_o = 8'h00;
  end
  // request held to the taking edge, idle cycle after so strobes never touch
  task automatic access(input logic wr, input logic [7:0] a,
    output logic [7:0] d, output logic ok, output logic [1:0] fl);
    rd_en_o = !wr;
    wr_en_o = wr;
    addr_o = a;
    @(posedge mclk_i);
    #1;
    d = rdata_i;
    ok = rvalid_i;
    fl = {err_i, refused_i};
    rd_en_o = 1'b0;
    wr_en_o = 1'b0;
    addr_o = ~a;
    @(posedge mclk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// [test/dmr_result_regs_chk.sv]
// port assertions for the result register bank
`timescale 1ns/1ns
`default_nettype none
module dmr_result_regs_chk #(
  parameter int unsigned NUM_CHAN = 7
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic conv_valid_i,
  input wire logic [3:0] conv_chan_i,
  input wire logic [11:0] conv_data_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic addr_err_o,
  input wire logic wr_refused_o,
  input wire logic [NUM_CHAN-1:0] fresh_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  chk_read_answer:
    assert property (rd_en_i |=> rvalid_o) else $error("no answer");
  chk_no_spur:
    assert property (!rd_en_i |=> !rvalid_o) else $error("stray answer");
  chk_data_holds:
    assert property (!rd_en_i |=> $stable(rdata_o)) else $error("data moved");
  chk_low_chan_id:
    assert property (rd_en_i && addr_i[0] && addr_i >= 8'h57
      && addr_i <= 8'h61 |=> rdata_o[3:0] == 4'(($past(addr_i) - 8'h57) >> 1))
    else $error("bad channel id");
  chk_unmapped_zero:
    assert property (rd_en_i && (addr_i < 8'h56 || addr_i > 8'h62)
      |=> addr_err_o && rdata_o == 8'h00) else $error("unmapped read");
  chk_mapped_ok:
    assert property (rd_en_i && !wr_en_i && addr_i >= 8'h56
      && addr_i <= 8'h62 |=> !addr_err_o) else $error("mapped flagged");
  chk_write_refused:
    assert property (1'b1 |=> wr_refused_o == $past(wr_en_i))
    else $error("write flag wrong");
  chk_fresh_set:
    assert property (conv_valid_i && conv_chan_i < 4'h7
      |=> fresh_o[$past(conv_chan_i)]) else $error("fresh not set");
  chk_out1_high:
    assert property (conv_valid_i && conv_chan_i == 4'h6 ##1 rd_en_i
      && addr_i == 8'h62 && !conv_valid_i
      |=> rdata_o == 8'($past(conv_data_i, 2) >> 4))
    else $error("bad 0x62");
endmodule
bind dmr_result_regs dmr_result_regs_chk #(.NUM_CHAN(NUM_CHAN)) u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .conv_valid_i(conv_valid_i),
  .conv_chan_i(conv_chan_i), .conv_data_i(conv_data_i), .rd_en_i(rd_en_i),
  .wr_en_i(wr_en_i), .addr_i(addr_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .addr_err_o(addr_err_o),
  .wr_refused_o(wr_refused_o), .fresh_o(fresh_o));
`default_nettype wire

// [test/dmr_result_regs_tb.sv]
// self-checking bench for the result register bank
`timescale 1ns/1ns
`default_nettype none
module dmr_result_regs_tb;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cv = 1'b0;
  logic [3:0] cch = 4'h0;
  logic [11:0] cd = 12'h000;
  logic rd_en, wr_en, rvalid, aerr, wref, ok;
  logic [7:0] addr, rdata, got;
  logic [1:0] fl;
  logic [6:0] fresh;
  int n_fail = 0;
  int total_checks = 0;
  always #4 mclk_i = ~mclk_i;
  dmr_result_regs u_dmr_result_regs (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .conv_valid_i(cv), .conv_chan_i(cch), .conv_data_i(cd),
    .rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr), .rdata_o(rdata),
    .rvalid_o(rvalid), .addr_err_o(aerr), .wr_refused_o(wref),
    .fresh_o(fresh));
  dmr_host_mdl u_dmr_host_mdl (.mclk_i(mclk_i), .rvalid_i(rvalid),
    .rdata_i(rdata), .err_i(aerr), .refused_i(wref), .rd_en_o(rd_en),
    .wr_en_o(wr_en), .addr_o(addr));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one read with its answer, valid and error flags compared
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic bad;
    bad = (a < 8'h56) || (a > 8'h62);
    u_dmr_host_mdl.access(1'b0, a, got, ok, fl);
    chk(got, exp);
    chk({7'h00, ok}, 8'h01);
    chk({6'h00, fl}, {6'h00, bad, 1'b0});
  endtask
  // one conversion result pulse
  task automatic conv(input logic [3:0] ch, input logic [11:0] d);
    cv = 1'b1;
    cch = ch;
    cd = d;
    @(posedge mclk_i);
    #1;
    cv = 1'b0;
    cd = ~d;
  endtask
  task automatic t_reset_map();
    for (int i = 0; i < 13; i++) begin
      rdc(8'h56 + 8'(i), i[0] ? {4'h0, 4'(i / 2)} : 8'h00);
    end
  endtask
  task automatic t_pairs();
    logic [11:0] d;
    for (int ch = 0; ch < 7; ch++) begin
      d = {4'(ch + 1), 4'hA, 4'(ch + 8)};
      conv(4'(ch), d);
      chk({7'h00, fresh[ch]}, 8'h01);
      rdc(8'h56 + 8'(2 * ch), d[11:4]);
      if (ch < 6) begin
        rdc(8'h57 + 8'(2 * ch), {d[3:0], 4'(ch)});
      end
      chk({7'h00, fresh[ch]}, 8'h00);
    end
  endtask
  task automatic t_snapshot();
    conv(4'h1, 12'h123);
    rdc(8'h58, 8'h12);
    conv(4'h1, 12'h456);
    rdc(8'h59, 8'h31);
    rdc(8'h59, 8'h61);
    rdc(8'h58, 8'h45);
  endtask
  // writes are refused and change nothing; foreign channel ids ignored
  task automatic t_refuse();
    u_dmr_host_mdl.access(1'b1, 8'h58, got, ok, fl);
    chk({6'h00, fl}, 8'h01);
    chk({7'h00, ok}, 8'h00);
    u_dmr_host_mdl.access(1'b1, 8'h70, got, ok, fl);
    chk({6'h00, fl}, 8'h03);
    rdc(8'h58, 8'h45);
    rdc(8'h55, 8'h00);
    rdc(8'h63, 8'h00);
    conv(4'hF, 12'hFFF);
    chk({1'b0, fresh}, 8'h00);
    rdc(8'h58, 8'h45);
  endtask
  // a result landing in the clearing cycle keeps its fresh flag
  task automatic t_race();
    fork
      conv(4'h2, 12'h5C7);
      rdc(8'h5B, 8'hA2);
    join
    chk({7'h00, fresh[2]}, 8'h01);
    rdc(8'h5B, 8'h72);
    chk({7'h00, fresh[2]}, 8'h00);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    t_reset_map();
    t_pairs();
    t_snapshot();
    t_refuse();
    t_race();
    close_out();
  end
endmodule
`default_nettype wire
